// ---- hdl/cpu8_opcode_addressing_decoder.sv ----
// Purpose: decode one opcode and form its effective or branch address
// Assumes: software loads opcode, operand bytes, index, pc and flags, then
//          writes the start bit; results are read back over AXI4-Lite
// Notes:   one decode per start; result is ready one cycle after start
`timescale 1ns/1ns
`default_nettype none
`include "cpu8_decode_defs.svh"

module cpu8_opcode_addressing_decoder
   import cpu8_decode_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        irq_pin,
   input  wire logic [7:0]  awaddr,
   input  wire logic [2:0]  awprot,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic [2:0]  arprot,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   output logic             branch_taken,
   output logic [15:0]      effective_address
);

   // software-loaded inputs of a decode
   logic [7:0]  opcode_reg;
   logic [15:0] operand_reg;
   logic [7:0]  index_reg;
   logic [15:0] pc_reg;
   logic [4:0]  condition_code_reg;
   // results
   logic [15:0] ea_reg;
   logic [15:0] next_pc_reg;
   logic        taken_reg;
   logic        done_reg;
   decode_s     info_reg;
   // combinational decode
   decode_s     dec_next;
   logic        cond_next;
   logic [15:0] ea_next;
   logic [15:0] next_pc_next;
   logic [15:0] seq_pc;
   logic [15:0] rel_off;
   // bus handshake state
   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        start_reg;
   logic        wr_fire;
   logic        wr_hit;

   // opcode table: group, mode, operation, bytes, cycles
   always_comb begin
      logic [3:0] hi;
      logic [3:0] lo;
      hi = opcode_reg[7:4];
      lo = opcode_reg[3:0];
      dec_next = '{legal: 1'b0, group: grp_none, mode: mode_illegal,
                   operation: 4'h0, byte_count: 2'd1, cycle_count: `CYC_CTRL};
      if (hi >= 4'ha) begin
         // register/memory group
         dec_next.legal = 1'b1;
         dec_next.group = grp_reg_mem;
         dec_next.operation = lo;
         case (hi)
            4'ha: begin
               dec_next.mode = mode_immediate;
               dec_next.byte_count = 2'd2;
               dec_next.cycle_count = `CYC_IMM;
            end
            4'hb: begin
               dec_next.mode = mode_direct;
               dec_next.byte_count = 2'd2;
               dec_next.cycle_count = `CYC_DIR;
            end
            4'hc: begin
               dec_next.mode = mode_extended;
               dec_next.byte_count = 2'd3;
               dec_next.cycle_count = `CYC_EXT;
            end
            4'hd: begin
               dec_next.mode = mode_indexed_word_offset;
               dec_next.byte_count = 2'd3;
               dec_next.cycle_count = `CYC_IX2;
            end
            4'he: begin
               dec_next.mode = mode_indexed_byte_offset;
               dec_next.byte_count = 2'd2;
               dec_next.cycle_count = `CYC_IX1;
            end
            default: begin
               dec_next.mode = mode_indexed;
               dec_next.byte_count = 2'd1;
               dec_next.cycle_count = `CYC_IX;
            end
         endcase
         // stores add one cycle, jumps one less, subroutine calls two more
         if (lo == 4'h7 || lo == 4'hf) begin
            dec_next.cycle_count = dec_next.cycle_count + 4'd1;
         end else if (lo == 4'hc) begin
            dec_next.cycle_count = dec_next.cycle_count - 4'd1;
         end else if (lo == 4'hd) begin
            dec_next.cycle_count = dec_next.cycle_count + 4'd2;
         end
         // immediate has no store or jump forms; ad is branch to subroutine
         if (hi == 4'ha && (lo == 4'h7 || lo == 4'hf || lo == 4'hc)) begin
            dec_next = '{legal: 1'b0, group: grp_none, mode: mode_illegal,
                         operation: 4'h0, byte_count: 2'd1, cycle_count: `CYC_CTRL};
         end else if (opcode_reg == `OP_BSR) begin
            dec_next.group = grp_branch;
            dec_next.mode = mode_relative;
            dec_next.cycle_count = `CYC_BSR;
         end
      end else if (hi >= 4'h3 && hi <= 4'h7) begin
         // read-modify-write group
         if (lo != 4'h1 && lo != 4'h2 && lo != 4'h5 && lo != 4'hb && lo != 4'he) begin
            dec_next.legal = 1'b1;
            dec_next.group = grp_rmw;
            dec_next.operation = lo;
            case (hi)
               4'h4, 4'h5: begin
                  dec_next.mode = mode_inherent;
                  dec_next.byte_count = 2'd1;
                  dec_next.cycle_count = `CYC_INH_RMW;
               end
               4'h3: begin
                  dec_next.mode = mode_direct;
                  dec_next.byte_count = 2'd2;
                  dec_next.cycle_count = `CYC_DIR_RMW;
               end
               4'h7: begin
                  dec_next.mode = mode_indexed;
                  dec_next.byte_count = 2'd1;
                  dec_next.cycle_count = `CYC_IX_RMW;
               end
               default: begin
                  dec_next.mode = mode_indexed_byte_offset;
                  dec_next.byte_count = 2'd2;
                  dec_next.cycle_count = `CYC_IX1_RMW;
               end
            endcase
            // test skips the write-back cycle, except in inherent mode
            if (lo == 4'hd && hi != 4'h4 && hi != 4'h5) begin
               dec_next.cycle_count = dec_next.cycle_count - 4'd1;
            end
         end else if (opcode_reg == `OP_MUL) begin
            dec_next.legal = 1'b1;
            dec_next.group = grp_rmw;
            dec_next.mode = mode_inherent;
            dec_next.operation = lo;
            dec_next.cycle_count = `CYC_MUL;
         end
      end else if (hi == 4'h2) begin
         dec_next.legal = 1'b1;
         dec_next.group = grp_branch;
         dec_next.mode = mode_relative;
         dec_next.operation = lo;
         dec_next.byte_count = 2'd2;
         dec_next.cycle_count = `CYC_BRANCH;
      end else if (hi == 4'h0 || hi == 4'h1) begin
         dec_next.legal = 1'b1;
         dec_next.group = grp_bit;
         dec_next.operation = {1'b0, lo[3:1]};
         if (hi == 4'h0) begin
            dec_next.mode = mode_bit_test_branch;
            dec_next.byte_count = 2'd3;
            dec_next.cycle_count = `CYC_BITBR;
         end else begin
            dec_next.mode = mode_direct;
            dec_next.byte_count = 2'd2;
            dec_next.cycle_count = `CYC_BITSET;
         end
      end else begin
         // control group
         case (opcode_reg)
            8'h97, 8'h9f, 8'h99, 8'h98, 8'h9b, 8'h9a, 8'h9c, 8'h9d, 8'h8e, 8'h8f: begin
               dec_next.legal = 1'b1;
               dec_next.cycle_count = `CYC_CTRL;
            end
            `OP_SWI: begin
               dec_next.legal = 1'b1;
               dec_next.cycle_count = `CYC_SWI;
            end
            `OP_RTS: begin
               dec_next.legal = 1'b1;
               dec_next.cycle_count = `CYC_RTS;
            end
            `OP_RTI: begin
               dec_next.legal = 1'b1;
               dec_next.cycle_count = `CYC_RTI;
            end
            default: begin
               dec_next.legal = 1'b0;
            end
         endcase
         if (dec_next.legal) begin
            dec_next.group = grp_control;
            dec_next.mode = mode_inherent;
            dec_next.operation = lo;
         end
      end
   end

   // branch condition select
   always_comb begin
      case (opcode_reg[3:0])
         4'h0: cond_next = 1'b1;
         4'h1: cond_next = 1'b0;
         4'h2: cond_next = ~(condition_code_reg[`CC_CARRY] | condition_code_reg[`CC_ZERO]);
         4'h3: cond_next = condition_code_reg[`CC_CARRY] | condition_code_reg[`CC_ZERO];
         4'h4: cond_next = ~condition_code_reg[`CC_CARRY];
         4'h5: cond_next = condition_code_reg[`CC_CARRY];
         4'h6: cond_next = ~condition_code_reg[`CC_ZERO];
         4'h7: cond_next = condition_code_reg[`CC_ZERO];
         4'h8: cond_next = ~condition_code_reg[`CC_HALF];
         4'h9: cond_next = condition_code_reg[`CC_HALF];
         4'ha: cond_next = ~condition_code_reg[`CC_NEG];
         4'hb: cond_next = condition_code_reg[`CC_NEG];
         4'hc: cond_next = ~condition_code_reg[`CC_MASK];
         4'hd: cond_next = condition_code_reg[`CC_MASK];
         4'he: cond_next = ~irq_pin;
         default: cond_next = irq_pin;
      endcase
   end

   // address forming; index is only read here
   always_comb begin
      seq_pc = pc_reg + {14'h0000, dec_next.byte_count};
      rel_off = (dec_next.mode == mode_bit_test_branch) ?
                {{8{operand_reg[7]}}, operand_reg[7:0]} : {{8{operand_reg[15]}}, operand_reg[15:8]};
      ea_next = 16'h0000;
      next_pc_next = seq_pc;
      case (dec_next.mode)
         mode_direct, mode_bit_test_branch: ea_next = {8'h00, operand_reg[15:8]};
         mode_extended: ea_next = operand_reg;
         mode_indexed: ea_next = {8'h00, index_reg};
         mode_indexed_byte_offset: ea_next = {8'h00, operand_reg[15:8]} + {8'h00, index_reg};
         mode_indexed_word_offset: ea_next = operand_reg + {8'h00, index_reg};
         mode_relative: ea_next = seq_pc + rel_off;
         default: ea_next = 16'h0000;
      endcase
      if (dec_next.mode == mode_relative && (cond_next || opcode_reg == `OP_BSR)) begin
         next_pc_next = ea_next;
      end
      if (dec_next.group == grp_reg_mem && dec_next.operation[3:1] == 3'b110) begin
         next_pc_next = ea_next;
      end
   end

   // result registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ea_reg <= 16'h0000;
         next_pc_reg <= `RST_PC;
         taken_reg <= 1'b0;
         info_reg <= '0;
         branch_taken <= 1'b0;
         effective_address <= 16'h0000;
      end else if (start_reg) begin
         ea_reg <= ea_next;
         next_pc_reg <= next_pc_next;
         taken_reg <= dec_next.mode == mode_relative && (cond_next || opcode_reg == `OP_BSR);
         info_reg <= dec_next;
         branch_taken <= dec_next.mode == mode_relative && (cond_next || opcode_reg == `OP_BSR);
         effective_address <= ea_next;
      end
   end

   // done flag: start clears, result sets
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= start_reg ? 1'b1 : (wr_hit && aw_addr_reg == `OFF_CTRL) ? 1'b0 : done_reg;
      end
   end

   // write channel capture, either order
   assign wr_fire = aw_held && w_held && !bvalid;
   assign wr_hit  = wr_fire && w_strb_reg[0];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= 2'b00;
      end else begin
         if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_addr_reg <= awaddr;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            w_held <= 1'b1;
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
            wready <= 1'b0;
         end
         if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= (aw_addr_reg <= `OFF_CCR && aw_addr_reg[1:0] == 2'b00) ? 2'b00 : 2'b10;
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // software-written registers and start pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         opcode_reg <= 8'h9d;
         operand_reg <= 16'h0000;
         index_reg <= 8'h00;
         pc_reg <= `RST_PC;
         condition_code_reg <= `RST_CCR;
         start_reg <= 1'b0;
      end else begin
         start_reg <= wr_hit && aw_addr_reg == `OFF_CTRL && w_data_reg[0];
         if (wr_fire) begin
            case (aw_addr_reg)
               `OFF_OPCODE: if (w_strb_reg[0]) opcode_reg <= w_data_reg[7:0];
               `OFF_OPER: begin
                  if (w_strb_reg[0]) operand_reg[7:0] <= w_data_reg[7:0];
                  if (w_strb_reg[1]) operand_reg[15:8] <= w_data_reg[15:8];
               end
               `OFF_INDEX: if (w_strb_reg[0]) index_reg <= w_data_reg[7:0];
               `OFF_PC: begin
                  if (w_strb_reg[0]) pc_reg[7:0] <= w_data_reg[7:0];
                  if (w_strb_reg[1]) pc_reg[15:8] <= w_data_reg[15:8];
               end
               `OFF_CCR: if (w_strb_reg[0]) condition_code_reg <= w_data_reg[4:0];
               default: ;
            endcase
         end
      end
   end

   // read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= 2'b00;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rresp <= 2'b00;
         case (araddr)
            `OFF_CTRL:   rdata <= 32'h0000_0000;
            `OFF_OPCODE: rdata <= {24'h000000, opcode_reg};
            `OFF_OPER:   rdata <= {16'h0000, operand_reg};
            `OFF_INDEX:  rdata <= {24'h000000, index_reg};
            `OFF_PC:     rdata <= {16'h0000, pc_reg};
            `OFF_CCR:    rdata <= {27'h0000000, condition_code_reg};
            `OFF_EA:     rdata <= {16'h0000, ea_reg};
            `OFF_INFO:   rdata <= {5'h00, info_reg};
            `OFF_NEXTPC: rdata <= {16'h0000, next_pc_reg};
            `OFF_STATUS: rdata <= {30'h00000000, taken_reg, done_reg};
            default: begin
               rdata <= 32'h0000_0000;
               rresp <= 2'b10;
            end
         endcase
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

endmodule
`default_nettype wire

// ---- hdl/cpu8_decode_defs.svh ----
// Purpose: constants for the opcode decoder and address former
// Assumes: byte-wide opcodes, 16-bit addresses
// Notes:   register map offsets, condition-code bit positions, cycle counts
`ifndef CPU8_DECODE_DEFS_SVH
`define CPU8_DECODE_DEFS_SVH

// register byte offsets on the bus
`define OFF_CTRL      8'h00
`define OFF_OPCODE    8'h04
`define OFF_OPER      8'h08
`define OFF_INDEX     8'h0c
`define OFF_PC        8'h10
`define OFF_CCR       8'h14
`define OFF_EA        8'h18
`define OFF_INFO      8'h1c
`define OFF_NEXTPC    8'h20
`define OFF_STATUS    8'h24

// reset values
`define RST_PC        16'h0000
`define RST_CCR       5'h08

// condition-code bit positions
`define CC_HALF       4
`define CC_MASK       3
`define CC_NEG        2
`define CC_ZERO       1
`define CC_CARRY      0

// fixed opcodes
`define OP_BSR        8'had
`define OP_MUL        8'h42
`define OP_SWI        8'h83
`define OP_RTS        8'h81
`define OP_RTI        8'h80

// cycle counts
`define CYC_BRANCH    4'd3
`define CYC_BSR       4'd6
`define CYC_BITBR     4'd5
`define CYC_BITSET    4'd5
`define CYC_MUL       4'd11
`define CYC_CTRL      4'd2
`define CYC_SWI       4'd10
`define CYC_RTS       4'd6
`define CYC_RTI       4'd9
`define CYC_INH_RMW   4'd3
`define CYC_DIR_RMW   4'd5
`define CYC_IX_RMW    4'd5
`define CYC_IX1_RMW   4'd6
`define CYC_IMM       4'd2
`define CYC_DIR       4'd3
`define CYC_EXT       4'd4
`define CYC_IX        4'd3
`define CYC_IX1       4'd4
`define CYC_IX2       4'd5

`endif

// ---- hdl/cpu8_decode_pkg.sv ----
// Purpose: types for the opcode decoder and address former
// Assumes: used together with cpu8_decode_defs.svh
// Notes:   decode result travels as one packed struct
`default_nettype none
package cpu8_decode_pkg;

   // addressing mode of a decoded opcode
   typedef enum logic [9:0] {
      mode_inherent = 10'h001,
      mode_immediate = 10'h002,
      mode_direct   = 10'h004,
      mode_extended = 10'h008,
      mode_indexed  = 10'h010,
      mode_indexed_byte_offset = 10'h020,
      mode_indexed_word_offset = 10'h040,
      mode_relative = 10'h080,
      mode_bit_test_branch = 10'h100,
      mode_illegal  = 10'h200
   } addr_mode_e;

   // instruction group
   typedef enum logic [5:0] {
      grp_reg_mem   = 6'h01,
      grp_rmw       = 6'h02,
      grp_branch    = 6'h04,
      grp_bit       = 6'h08,
      grp_control   = 6'h10,
      grp_none      = 6'h20
   } group_e;

   // full decode of one opcode
   typedef struct packed {
      logic       legal;
      group_e     group;
      addr_mode_e mode;
      logic [3:0] operation;
      logic [1:0] byte_count;
      logic [3:0] cycle_count;
   } decode_s;

   // bus-side request state
   typedef enum logic [2:0] {
      bus_idle  = 3'h1,
      bus_wait  = 3'h2,
      bus_resp  = 3'h4
   } bus_state_e;

endpackage
`default_nettype wire

// ---- testbench/cpu8_decoder_props.sv ----
// Purpose: timing checks on the decoder bus and result ports
// Assumes: one clock, reset synchronous and active low
// Notes:   bound to every instance of the decoder top
`timescale 1ns/1ns
`default_nettype none
module cpu8_decoder_props (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic        branch_taken,
   input wire logic [15:0] effective_address
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // both write channels taken on one edge
   sequence s_wr_both;
      awvalid && awready && wvalid && wready;
   endsequence
   // response accepted, then the channel reopens
   sequence s_b_done;
      bvalid && bready;
   endsequence
   sequence s_b_reopen;
      !bvalid && awready && wready;
   endsequence
   a_write_answer: assert property (s_wr_both |-> ##[1:2] bvalid)
      else $error("write response missing");
   a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read data late");
   a_write_busy: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while response pending");
   a_read_busy: assert property (rvalid |-> !arready)
      else $error("read taken while data pending");
   a_b_release: assert property (s_b_done |=> s_b_reopen)
      else $error("write channel not reopened");
   a_r_release: assert property (rvalid && rready |=> !rvalid && arready)
      else $error("read channel not reopened");
   a_resp_code: assert property (bvalid |-> bresp == 2'b00 || bresp == 2'b10)
      else $error("bad write response code");
   a_refused_zero: assert property (rvalid && rresp == 2'b10 |-> rdata == 32'h0)
      else $error("refused read carries data");
   a_result_cause: assert property ($changed(effective_address) || $changed(branch_taken) |-> $past(bvalid))
      else $error("result changed without a start");
endmodule
bind cpu8_opcode_addressing_decoder cpu8_decoder_props u_props (.aclk, .aresetn, .awvalid, .awready, .wvalid,
   .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .branch_taken,
   .effective_address);
`default_nettype wire

// ---- testbench/irq_line_model.sv ----
// Purpose: external interrupt line feeding the decoder pin
// Assumes: level requested by the bench
// Notes:   line settles one clock after a request
`timescale 1ns/1ns
`default_nettype none
module irq_line_model (
   input  wire logic aclk,
   input  wire logic level,
   output var logic  irq_pin = 1'b0
);
   // pin follows the requested level
   always @(posedge aclk) begin
      irq_pin <= level;
   end
endmodule
`default_nettype wire

// ---- testbench/cpu8_opcode_addressing_decoder_bench.sv ----
// Purpose: self-checking bench for the opcode decoder
// Assumes: registers reached over AXI4-Lite, response readies held high
// Notes:   each decode loads inputs, starts, polls done, reads results
`timescale 1ns/1ns
`default_nettype none
`include "cpu8_decode_defs.svh"
`define chk(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module cpu8_opcode_addressing_decoder_bench;
   logic        aclk, aresetn, irq_level, irq_pin, branch_taken;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [2:0]  awprot, arprot;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, bsp, rsp;
   logic [7:0]  awaddr, araddr;
   logic [15:0] effective_address, ea, npc;
   logic [31:0] wdata, rdata, rv, info;
   int          n_errors, checks, cycles;

   cpu8_opcode_addressing_decoder u_dut (.aclk, .aresetn, .irq_pin, .awaddr, .awprot, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready,
      .rdata, .rresp, .rvalid, .rready, .branch_taken, .effective_address);
   irq_line_model u_irq (.aclk, .level(irq_level), .irq_pin);

   // clock generator
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   // one write, both channels offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bsp = bresp;
   endtask

   // one read
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rv = rdata;
      rsp = rresp;
   endtask

   // load one decode, start it, collect the results
   task automatic dec(input logic [7:0] op, input logic [15:0] opr, input logic [7:0] ix,
                      input logic [15:0] pc, input logic [4:0] cc);
      wr(`OFF_CTRL, 32'h0);
      wr(`OFF_OPCODE, 32'(op));
      wr(`OFF_OPER, 32'(opr));
      wr(`OFF_INDEX, 32'(ix));
      wr(`OFF_PC, 32'(pc));
      wr(`OFF_CCR, 32'(cc));
      wr(`OFF_CTRL, 32'h1);
      do rd(`OFF_STATUS); while (rv[0] !== 1'b1);
      rd(`OFF_INFO);
      info = rv;
      rd(`OFF_EA);
      ea = rv[15:0];
      rd(`OFF_NEXTPC);
      npc = rv[15:0];
   endtask

   // reset value, unmapped read, read-only write
   task automatic t_regs;
      rd(`OFF_CCR);
      `chk(rv[4:0], `RST_CCR)
      rd(8'h40);
      `chk({rsp, rv}, {2'b10, 32'h0})
      wr(`OFF_EA, 32'h1);
      `chk(bsp, 2'b10)
   endtask

   // byte offset and index at the top of their ranges, then a mid-range word offset
   task automatic t_index;
      dec(8'he6, 16'hff00, 8'hff, 16'h0200, 5'h08);
      `chk(ea, 16'h01fe)
      `chk(effective_address, 16'h01fe)
      `chk({info[19:10], info[5:0]}, {10'h020, 6'h24})
      `chk(info[9:6], 4'h6)
      `chk(npc, 16'h0202)
      rd(`OFF_INDEX);
      `chk(rv[7:0], 8'hff)
      dec(8'hd6, 16'h0700, 8'h05, 16'h0200, 5'h08);
      `chk(ea, 16'h0705)
      `chk({info[19:10], info[5:0]}, {10'h040, 6'h35})
      `chk(npc, 16'h0203)
   endtask

   // all sixteen conditions against single flags and the pin
   task automatic t_branch;
      logic [4:0] cc;
      logic [7:0] op, off, f;
      logic       t;
      for (int k = 0; k < 96; k++) begin
         op = 8'h20 + 8'(k / 6);
         cc = (k % 6 == 0) ? 5'h00 : 5'(1 << (k % 6 - 1));
         off = k[0] ? 8'h80 : 8'h7f;
         irq_level <= k[1];
         f = {k[1], cc[3], cc[2], cc[4], cc[1], cc[0], cc[0] | cc[1], 1'b0};
         t = f[op[3:1]] ^ ~op[0];
         dec(op, {off, 8'h00}, 8'h00, 16'h0200, cc);
         `chk(branch_taken, t)
         `chk(npc, t ? 16'h0202 + {{8{off[7]}}, off} : 16'h0202)
         `chk(info[5:0], 6'h23)
      end
      dec(8'had, 16'h0500, 8'h00, 16'h0200, 5'h00);
      `chk({branch_taken, npc, info[5:0]}, {1'b1, 16'h0207, 6'h26})
   endtask

   // modes, byte and cycle counts across the groups
   task automatic t_table;
      logic [31:0] tab [25] = '{32'ha6_002_0a2, 32'hb6_004_0a3, 32'hf6_010_093, 32'hc7_008_0b5,
         32'hff_010_094, 32'hbc_004_0a2, 32'hdc_040_0b4, 32'hfd_010_095, 32'hdd_040_0b7,
         32'h4c_001_093, 32'h5c_001_093, 32'h3c_004_0a5, 32'h7c_010_095, 32'h6c_020_0a6,
         32'h3d_004_0a4, 32'h6d_020_0a5, 32'h42_001_09b, 32'h97_001_092, 32'h83_001_09a,
         32'h81_001_096, 32'h80_001_099, 32'h8e_001_092, 32'h03_100_0b5, 32'ha7_200_012, 32'h14_004_0a5};
      foreach (tab[i]) begin
         dec(tab[i][31:24], 16'h1234, 8'h00, 16'h0200, 5'h00);
         `chk(info[26], tab[i][7])
         `chk(info[19:10], tab[i][21:12])
         `chk(info[5:0], tab[i][5:0])
         `chk(info[9:6], tab[i][31:29] == 3'h0 ? {1'b0, tab[i][27:25]} : tab[i][7] ? tab[i][27:24] : 4'h0)
      end
   endtask

   // verdict and end of run
   task automatic wrap_up;
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // watchdog on the whole run
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_errors++;
         wrap_up;
      end
   end

   // reset, then the scenarios in turn
   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, arvalid, irq_level} = 4'h0;
      {bready, rready} = 2'h3;
      {awprot, arprot, wstrb} = 10'h00f;
      {awaddr, araddr, wdata} = 48'h0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs;
      t_index;
      t_branch;
      t_table;
      wrap_up;
   end
endmodule
`default_nettype wire
